// file: design/modem_line_pkg.sv
// Shared constants and carrier types for the modem line logic.
package modem_line_pkg;
    localparam int          CLOCK_HZ             = 40_000_000;
    localparam int          CYCLES_PER_MS        = CLOCK_HZ / 1000;
    localparam int          BREAK_TIME_MS        = 100;
    localparam int          BREAK_CYCLES         = BREAK_TIME_MS * CYCLES_PER_MS;
    localparam logic [13:0] RECONNECT_DEFAULT_MS = 14'h07D0;
    localparam logic [13:0] RECONNECT_MIN_MS     = 14'h0064;
    localparam logic [13:0] RECONNECT_MAX_MS     = 14'h3A98;
    localparam logic [1:0]  DSR_IGNORED          = 2'h0;
    localparam logic [1:0]  DSR_DROP_ONLY        = 2'h2;
    localparam logic [2:0]  MODE_CONNECT_ONLY    = 3'h3;
    localparam logic [2:0]  MODE_CONNECT_DISC    = 3'h4;
    localparam int          IO_COUNT             = 7;
    localparam int          DTR_IO               = 0;
    localparam int          OSC_ACC_W            = 16;
    localparam longint      OSC_SLOW_HZ          = 8_000_000;
    localparam longint      OSC_FAST_HZ          = 16_000_000;
    localparam logic [15:0] OSC_STEP_SLOW        = 16'((OSC_SLOW_HZ << OSC_ACC_W) / CLOCK_HZ);
    localparam logic [15:0] OSC_STEP_FAST        = 16'((OSC_FAST_HZ << OSC_ACC_W) / CLOCK_HZ);
    localparam int          SYNC_W               = 12;
    localparam int          SY_RX                = 0;
    localparam int          SY_CTS               = 1;
    localparam int          SY_DSR               = 2;
    localparam int          SY_RI                = 3;
    localparam int          SY_DCD               = 4;
    localparam int          SY_IO                = 5;
    localparam logic [11:0] SYNC_RESET           = 12'hFFF;

    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_DSR  = 3'h1,
        SRC_CTS  = 3'h2,
        SRC_RI   = 3'h3,
        SRC_DCD  = 3'h4,
        SRC_DTR  = 3'h5,
        SRC_RTS  = 3'h6,
        SRC_LINK = 3'h7
    } line_src_t;

    typedef enum logic [1:0] {
        AC_IDLE   = 2'h0,
        AC_DIAL   = 2'h1,
        AC_LINKED = 2'h3,
        AC_WAIT   = 2'h2
    } auto_state_t;

    typedef struct packed {
        logic rtr;
        logic rtc;
        logic dv;
        logic ic;
    } peer_status_t;

    typedef struct packed {
        logic        ri_is_output;
        logic        dcd_is_output;
        logic        pure_host_mode;
        logic        cable_replacement;
        logic        is_master;
        logic        dtr_on_line_three;
        logic [1:0]  dsr_handling_setting;
        logic [2:0]  connectable_discoverable_mode;
        logic [15:0] drop_timeout_ms;
        logic [13:0] reconnect_delay_setting;
        logic        osc_enable;
        logic        osc_fast;
        logic [2:0]  osc_line;
    } modem_cfg_t;

    typedef struct packed {
        line_src_t [3:0] to_peer;
        logic [2:0]      dtr_from;
        logic [2:0]      ri_from;
        logic [2:0]      dcd_from;
    } map_cfg_t;
endpackage : modem_line_pkg

// file: design/interval_timer.sv
// Run-length timer that fires once when its run input has lasted the limit.
module interval_timer #(
    parameter int W = 16
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         run,
    input  wire logic         step,
    input  wire logic [W-1:0] limit,
    output logic              fire,
    output logic              expired
);
    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;
    logic         expired_ff;
    logic         fire_ff;
    wire          reached = count_ff >= limit;

    // Dropping run clears the count, so only an unbroken run can expire.
    assign nxt_count = !run ? '0 : (step && !reached) ? count_ff + 1'b1 : count_ff;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_ff   <= '0;
            expired_ff <= 1'b0;
            fire_ff    <= 1'b0;
        end else begin
            count_ff   <= nxt_count;
            expired_ff <= run && reached;
            fire_ff    <= run && reached && !expired_ff;
        end
    end

    assign fire    = fire_ff;
    assign expired = expired_ff;
endmodule : interval_timer

// file: design/modem_lines.sv
// Modem control and status lines, shared I/O, break reset and auto connect.

module modem_lines #(
    parameter int BREAK_CYCLES  = modem_line_pkg::BREAK_CYCLES,
    parameter int CYCLES_PER_MS = modem_line_pkg::CYCLES_PER_MS
) (
    input  wire logic                         clock,
    input  wire logic                         reset_n,
    input  wire modem_line_pkg::modem_cfg_t   cfg,
    input  wire modem_line_pkg::map_cfg_t     line_map,
    input  wire logic                         rx_pin,
    output logic                              rx_to_uart,
    input  wire logic                         cts_pin_n,
    output logic                              rts_pin_n,
    input  wire logic                         rx_buffer_full,
    output logic                              tx_allowed,
    input  wire logic                         dsr_pin_n,
    input  wire logic                         ri_pin_in_n,
    output logic                              ri_pin_out_n,
    output logic                              ri_pin_oe_n,
    input  wire logic                         dcd_pin_in_n,
    output logic                              dcd_pin_out_n,
    output logic                              dcd_pin_oe_n,
    input  wire logic [6:0]                   io_pin_in,
    output logic [6:0]                        io_pin_out,
    output logic [6:0]                        io_pin_oe_n,
    input  wire logic [6:0]                   io_drive_value,
    input  wire logic [6:0]                   io_drive_enable,
    output logic [6:0]                        io_level,
    input  wire modem_line_pkg::peer_status_t peer_in,
    output modem_line_pkg::peer_status_t      peer_out,
    input  wire logic                         link_up,
    input  wire logic                         connect_failed,
    output logic                              connect_request,
    input  wire logic                         incoming_call,
    input  wire logic [47:0]                  incoming_addr,
    input  wire logic                         answer_call_command,
    input  wire logic                         hang_up_command,
    input  wire logic                         store_peer_address_command,
    input  wire logic [47:0]                  store_addr,
    output logic                              accept_incoming,
    output logic                              reject_incoming,
    input  wire logic                         call_request,
    output logic                              call_error,
    output logic                              call_started,
    output logic                              command_state,
    output logic                              drop_request,
    output logic                              hw_reset_request,
    output logic                              connectable,
    output logic                              discoverable
);
    logic [modem_line_pkg::SYNC_W-1:0] sync1_ff;
    logic [modem_line_pkg::SYNC_W-1:0] sync2_ff;
    logic [15:0]                       ms_count_ff;
    logic [15:0]                       osc_acc_ff;
    logic [47:0]                       peer_addr_ff;
    logic                              peer_valid_ff;
    logic                              ring_ff;
    logic                              rx_to_uart_ff;
    logic                              rts_pin_n_ff;
    logic                              ri_out_n_ff;
    logic                              ri_oe_n_ff;
    logic                              dcd_out_n_ff;
    logic                              dcd_oe_n_ff;
    logic [6:0]                        io_out_ff;
    logic [6:0]                        io_oe_n_ff;
    logic [3:0]                        peer_out_ff;
    logic                              accept_ff;
    logic                              reject_ff;
    logic                              call_error_ff;
    logic                              call_started_ff;
    logic                              command_state_ff;
    logic                              connectable_ff;
    logic                              discoverable_ff;
    modem_line_pkg::auto_state_t       state_ff;
    modem_line_pkg::auto_state_t       nxt_state;
    logic [6:0]                        nxt_io_out;
    logic [6:0]                        nxt_io_oe_n;
    logic [3:0]                        nxt_peer_out;
    logic [7:0]                        line_vec;
    logic                              break_seen;
    logic                              retry_fire;

    // Local line value, either the block's own function or one peer status bit.
    function automatic logic pick_line(input logic [2:0] from, input logic own,
                                       input logic [3:0] peer);
        if (from == 3'h0)
            return own;
        return peer[2'(from - 3'h1)];
    endfunction : pick_line

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync1_ff <= modem_line_pkg::SYNC_RESET;
            sync2_ff <= modem_line_pkg::SYNC_RESET;
        end else begin
            sync1_ff <= {io_pin_in, dcd_pin_in_n, ri_pin_in_n, dsr_pin_n, cts_pin_n, rx_pin};
            sync2_ff <= sync1_ff;
        end
    end

    wire rx_s   = sync2_ff[modem_line_pkg::SY_RX];
    wire cts    = !sync2_ff[modem_line_pkg::SY_CTS];
    wire dsr    = !sync2_ff[modem_line_pkg::SY_DSR];
    wire ri_in  = !sync2_ff[modem_line_pkg::SY_RI];
    wire dcd_in = !sync2_ff[modem_line_pkg::SY_DCD];
    assign io_level = sync2_ff[modem_line_pkg::SY_IO +: 7];

    wire ms_tick = ms_count_ff == 16'(CYCLES_PER_MS - 1);

    wire dsr_aware = cfg.dsr_handling_setting != modem_line_pkg::DSR_IGNORED;
    wire drop_run  = link_up && dsr_aware && !dsr;

    // break length measured in clock cycles
    interval_timer #(.W(23)) break_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .run     (!rx_s),
        .step    (1'b1),
        .limit   (23'(BREAK_CYCLES)),
        .fire    (hw_reset_request),
        .expired (break_seen)
    );

    interval_timer #(.W(16)) drop_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .run     (drop_run),
        .step    (ms_tick),
        .limit   (cfg.drop_timeout_ms),
        .fire    (drop_request),
        .expired ()
    );

    // reconnect delay clamped to its range
    wire [13:0] delay_set = cfg.reconnect_delay_setting;
    wire [13:0] retry_ms  = (delay_set == 14'h0000) ? modem_line_pkg::RECONNECT_DEFAULT_MS :
                            (delay_set < modem_line_pkg::RECONNECT_MIN_MS) ?
                                modem_line_pkg::RECONNECT_MIN_MS :
                            (delay_set > modem_line_pkg::RECONNECT_MAX_MS) ?
                                modem_line_pkg::RECONNECT_MAX_MS : delay_set;

    interval_timer #(.W(14)) retry_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .run     (state_ff == modem_line_pkg::AC_WAIT),
        .step    (ms_tick),
        .limit   (retry_ms),
        .fire    (retry_fire),
        .expired ()
    );

    wire addr_ok = !peer_valid_ff || (incoming_addr == peer_addr_ff);
    // ring holds until answered or hung up; a new accepted call wins
    wire nxt_ring = (incoming_call && addr_ok) ||
                    (ring_ff && !answer_call_command && !hang_up_command);

    wire dcd_own = link_up;
    // direction picks driven or sensed value
    wire ri_val  = cfg.ri_is_output ? pick_line(line_map.ri_from, ring_ff, peer_in) : ri_in;
    wire dcd_val = cfg.dcd_is_output ? pick_line(line_map.dcd_from, dcd_own, peer_in) : dcd_in;
    // pure host ties terminal-ready to the connection
    wire dtr_val = cfg.pure_host_mode ? link_up : pick_line(line_map.dtr_from, link_up, peer_in);
    wire dtr_claim = cfg.pure_host_mode || cfg.dtr_on_line_three;

    // local lines offered to the peer status bits
    assign line_vec = {link_up, !rx_buffer_full, dtr_val, dcd_val, ri_val, cts, dsr, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_peer
            assign nxt_peer_out[gi] = line_vec[line_map.to_peer[gi]];
        end
        for (gi = 0; gi < modem_line_pkg::IO_COUNT; gi++) begin : g_io
            wire osc_claim = cfg.osc_enable && (cfg.osc_line == 3'(gi));
            wire own_dtr   = (gi == modem_line_pkg::DTR_IO) && dtr_claim;
            assign nxt_io_out[gi]  = own_dtr ? !dtr_val :
                                     osc_claim ? osc_acc_ff[15] : io_drive_value[gi];
            assign nxt_io_oe_n[gi] = !(own_dtr || osc_claim || io_drive_enable[gi]);
        end
    endgenerate

    wire auto_enable = cfg.cable_replacement && cfg.is_master;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            modem_line_pkg::AC_IDLE:
                if (auto_enable && dsr)
                    nxt_state = modem_line_pkg::AC_DIAL;
            modem_line_pkg::AC_DIAL:
                if (link_up)
                    nxt_state = modem_line_pkg::AC_LINKED;
                else if (connect_failed)
                    nxt_state = modem_line_pkg::AC_WAIT;
            modem_line_pkg::AC_LINKED:
                if (!link_up)
                    nxt_state = modem_line_pkg::AC_WAIT;
            modem_line_pkg::AC_WAIT:
                if (retry_fire)
                    nxt_state = modem_line_pkg::AC_DIAL;
            default:
                nxt_state = modem_line_pkg::AC_IDLE;
        endcase
        // no dialling without the host holding DSR
        if (!auto_enable || (!dsr && state_ff != modem_line_pkg::AC_LINKED))
            nxt_state = modem_line_pkg::AC_IDLE;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_ff    <= modem_line_pkg::AC_IDLE;
            ms_count_ff <= 16'h0000;
            osc_acc_ff  <= 16'h0000;
        end else begin
            state_ff    <= nxt_state;
            ms_count_ff <= ms_tick ? 16'h0000 : ms_count_ff + 16'h0001;
            // phase accumulator gives the slow or fast output
            osc_acc_ff  <= osc_acc_ff + (cfg.osc_fast ? modem_line_pkg::OSC_STEP_FAST
                                                      : modem_line_pkg::OSC_STEP_SLOW);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            peer_addr_ff  <= 48'h000000000000;
            peer_valid_ff <= 1'b0;
            ring_ff       <= 1'b0;
            accept_ff     <= 1'b0;
            reject_ff     <= 1'b0;
        end else begin
            if (store_peer_address_command) begin
                peer_addr_ff  <= store_addr;
                peer_valid_ff <= 1'b1;
            end
            ring_ff   <= nxt_ring;
            accept_ff <= incoming_call && addr_ok;
            reject_ff <= incoming_call && !addr_ok;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_to_uart_ff    <= 1'b1;
            rts_pin_n_ff     <= 1'b1;
            ri_out_n_ff      <= 1'b1;
            ri_oe_n_ff       <= 1'b1;
            dcd_out_n_ff     <= 1'b1;
            dcd_oe_n_ff      <= 1'b1;
            io_out_ff        <= 7'h7F;
            io_oe_n_ff       <= 7'h7F;
            peer_out_ff      <= 4'h0;
            call_error_ff    <= 1'b0;
            call_started_ff  <= 1'b0;
            command_state_ff <= 1'b1;
            connectable_ff   <= 1'b0;
            discoverable_ff  <= 1'b0;
        end else begin
            // a held break reads as idle, so nothing reaches the peer
            rx_to_uart_ff    <= rx_s || break_seen;
            // RTS withdrawn while the receive buffer is full
            rts_pin_n_ff     <= rx_buffer_full;
            ri_out_n_ff      <= !ri_val;
            ri_oe_n_ff       <= !cfg.ri_is_output;
            dcd_out_n_ff     <= !dcd_val;
            dcd_oe_n_ff      <= !cfg.dcd_is_output;
            io_out_ff        <= nxt_io_out;
            io_oe_n_ff       <= nxt_io_oe_n;
            peer_out_ff      <= nxt_peer_out;
            call_error_ff    <= call_request && !dsr;
            call_started_ff  <= call_request && dsr;
            // DSR loss in call leaves data state unless DSR handling is set to ignored
            command_state_ff <= !link_up || (dsr_aware && !dsr);
            // scan modes of the slave only
            connectable_ff   <= !cfg.is_master &&
                                (cfg.connectable_discoverable_mode == modem_line_pkg::MODE_CONNECT_ONLY ||
                                 cfg.connectable_discoverable_mode == modem_line_pkg::MODE_CONNECT_DISC);
            discoverable_ff  <= !cfg.is_master &&
                                cfg.connectable_discoverable_mode == modem_line_pkg::MODE_CONNECT_DISC;
        end
    end

    // CTS gates the transmitter directly; the host is trusted to honour RTS.
    assign tx_allowed      = cts;
    assign rx_to_uart      = rx_to_uart_ff;
    assign rts_pin_n       = rts_pin_n_ff;
    assign ri_pin_out_n    = ri_out_n_ff;
    assign ri_pin_oe_n     = ri_oe_n_ff;
    assign dcd_pin_out_n   = dcd_out_n_ff;
    assign dcd_pin_oe_n    = dcd_oe_n_ff;
    assign io_pin_out      = io_out_ff;
    assign io_pin_oe_n     = io_oe_n_ff;
    assign peer_out        = modem_line_pkg::peer_status_t'(peer_out_ff);
    assign accept_incoming = accept_ff;
    assign reject_incoming = reject_ff;
    assign call_error      = call_error_ff;
    assign call_started    = call_started_ff;
    assign command_state   = command_state_ff;
    assign connectable     = connectable_ff;
    assign discoverable    = discoverable_ff;
    assign connect_request = state_ff == modem_line_pkg::AC_DIAL;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_rts_full: assert property (rx_buffer_full |=> rts_pin_n)
        else $error("RTS not withdrawn on full buffer");
    chk_call_no_dsr: assert property (call_request && !dsr |=> call_error && !call_started)
        else $error("call without DSR not refused");
    chk_command_fall: assert property (drop_run |=> command_state)
        else $error("DSR loss did not enter command state");
    chk_drop_cause: assert property (drop_request |-> command_state && !$past(dsr))
        else $error("drop without DSR loss");
    chk_ring_hold: assert property (cfg.ri_is_output && line_map.ri_from == 3'h0 && ring_ff
                                    |=> !ri_pin_out_n)
        else $error("ring not shown on RI");
    chk_dcd_link: assert property (cfg.dcd_is_output && line_map.dcd_from == 3'h0 && link_up
                                   |=> !dcd_pin_out_n)
        else $error("DCD not asserted while connected");
    chk_pure_host_dtr: assert property (cfg.pure_host_mode && link_up
                                        |=> !io_pin_out[0] && !io_pin_oe_n[0])
        else $error("line three not driving DTR");
    chk_break_reset: assert property (hw_reset_request |-> !$past(rx_s) ##1 rx_to_uart)
        else $error("reset without break or break forwarded");
    chk_wait_no_dial: assert property (state_ff == modem_line_pkg::AC_WAIT && !retry_fire
                                       |=> !connect_request)
        else $error("dialling during reconnect delay");
    chk_open_accept: assert property (incoming_call && !peer_valid_ff |=> accept_incoming)
        else $error("open slave refused a caller");
    chk_master_hidden: assert property (cfg.is_master |=> !discoverable)
        else $error("master became discoverable");

    cov_call_error: cover property (call_request && !dsr ##1 call_error);
    cov_break: cover property (hw_reset_request);
    cov_retry: cover property (state_ff == modem_line_pkg::AC_WAIT ##1
                               state_ff == modem_line_pkg::AC_DIAL);
endmodule : modem_lines

// file: sim/host_model.sv
// Host terminal model driving the serial port lines.
module host_model (
    input  wire logic dsr_on,
    input  wire logic brk,
    input  wire logic rts_pin_n,
    output logic      dsr_pin_n,
    output logic      rx_pin,
    output logic      cts_pin_n
);
    timeunit 1ns;
    timeprecision 100ps;
    assign dsr_pin_n = !dsr_on;
    assign cts_pin_n = rts_pin_n;
    assign rx_pin    = !brk;
endmodule : host_model

// file: sim/serial_modem_line_control_tb.sv
// Self-checking bench for the modem line block.
module serial_modem_line_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, reset_n, rx_pin, cts_pin_n, rx_buffer_full, dsr_pin_n, dsr_on, brk;
    logic ri_pin_in_n, dcd_pin_in_n, link_up, connect_failed, incoming_call, call_request;
    logic answer_call_command, hang_up_command, store_peer_address_command;
    logic rx_to_uart, rts_pin_n, tx_allowed, ri_pin_out_n, ri_pin_oe_n, dcd_pin_out_n;
    logic dcd_pin_oe_n, connect_request, accept_incoming, reject_incoming, call_error;
    logic call_started, command_state, drop_request, hw_reset_request, connectable;
    logic discoverable;
    logic [6:0] io_pin_in, io_pin_out, io_pin_oe_n, io_drive_value, io_drive_enable, io_level;
    logic [47:0] incoming_addr, store_addr;
    modem_line_pkg::modem_cfg_t   cfg;
    modem_line_pkg::map_cfg_t     line_map;
    modem_line_pkg::peer_status_t peer_in, peer_out;
    int errors, samples_checked, n;
    logic osc_prev;
    // Short counts keep the break and millisecond timers inside a brief run.
    modem_lines #(.BREAK_CYCLES(40), .CYCLES_PER_MS(10)) uut (.*);
    host_model host (.dsr_on(dsr_on), .brk(brk), .rts_pin_n(rts_pin_n),
        .dsr_pin_n(dsr_pin_n), .rx_pin(rx_pin), .cts_pin_n(cts_pin_n));
    task automatic chk(input string what, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %b seen %b", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask : cyc
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic test_call;
        dsr_on = 0; cyc(4); call_request = 1; cyc(1);
        chk("call_error", call_error, 1'h1);
        call_request = 0; dsr_on = 1; cyc(4); call_request = 1; cyc(1);
        chk("call_started", call_started, 1'h1);
        call_request = 0; $display("test_call done");
    endtask : test_call
    task automatic test_ring;
        incoming_call = 1; cyc(1);
        chk("accept", accept_incoming, 1'h1);
        incoming_call = 0; cyc(4);
        chk("ri_on", ri_pin_out_n, 1'h0);
        chk("ri_oe", ri_pin_oe_n, 1'h0);
        answer_call_command = 1; cyc(1); answer_call_command = 0; cyc(2);
        chk("ri_off", ri_pin_out_n, 1'h1);
        $display("test_ring done");
    endtask : test_ring
    task automatic test_link;
        link_up = 1; cyc(4);
        chk("dcd_on", dcd_pin_out_n, 1'h0);
        chk("dtr_line", io_pin_out[0] | io_pin_oe_n[0], 1'h0);
        chk("data_state", command_state, 1'h0);
        dsr_on = 0; cyc(4);
        chk("cmd_state", command_state, 1'h1);
        cyc(11); dsr_on = 1; n = 0;
        repeat (60) begin cyc(1); n += int'(drop_request); end
        chk("no_drop", n == 0, 1'h1);
        dsr_on = 0; n = 0;
        while (drop_request !== 1'h1 && n < 80) begin cyc(1); n++; end
        chk("drop_time", n inside {[20:45]}, 1'h1);
        dsr_on = 1; link_up = 0; cyc(4);
        chk("dcd_off", dcd_pin_out_n, 1'h1);
        $display("test_link done");
    endtask : test_link
    task automatic test_break;
        brk = 1; n = 0;
        while (hw_reset_request !== 1'h1 && n < 80) begin cyc(1); n++; end
        chk("break_time", n inside {[40:50]}, 1'h1);
        cyc(1); chk("rx_idle", rx_to_uart, 1'h1);
        brk = 0; $display("test_break done");
    endtask : test_break
    task automatic test_flow;
        rx_buffer_full = 1; cyc(1);
        chk("rts_off", rts_pin_n, 1'h1);
        cyc(3); chk("cts_off", tx_allowed, 1'h0);
        rx_buffer_full = 0; cyc(4);
        chk("cts_on", tx_allowed & !rts_pin_n, 1'h1);
        $display("test_flow done");
    endtask : test_flow
    task automatic test_map;
        store_peer_address_command = 1'b1; store_addr = 48'h0000000000A1; cyc(1);
        store_peer_address_command = 1'b0; incoming_addr = 48'h0000000000B2;
        incoming_call = 1'b1; cyc(1);
        chk("reject", reject_incoming & !accept_incoming, 1'h1);
        incoming_addr = 48'h0000000000A1; cyc(1); incoming_call = 1'b0;
        chk("accept_stored", accept_incoming, 1'h1);
        cyc(1); chk("ri_ring", ri_pin_out_n, 1'h0);
        hang_up_command = 1'b1; cyc(1); hang_up_command = 1'b0; cyc(1);
        chk("ri_hang_up", ri_pin_out_n, 1'h1);
        line_map.to_peer[3] = modem_line_pkg::SRC_DSR; line_map.ri_from = 3'h1;
        peer_in.ic = 1'b1; io_pin_in = 7'h55; io_drive_value = 7'h02; io_drive_enable = 7'h02;
        cfg.dcd_is_output = 1'b0;
        cfg.connectable_discoverable_mode = modem_line_pkg::MODE_CONNECT_ONLY; cyc(3);
        chk("peer_rtr", peer_out.rtr & !peer_out.ic, 1'h1);
        chk("ri_from_peer", ri_pin_out_n, 1'h0);
        chk("io_level", io_level == 7'h55, 1'h1);
        chk("io_drive", io_pin_out[1] & !io_pin_oe_n[1], 1'h1);
        chk("dcd_input", dcd_pin_oe_n, 1'h1);
        chk("connectable", connectable & !discoverable, 1'h1);
        cfg.osc_enable = 1'b1; cfg.osc_line = 3'h2; cyc(2); n = 0; osc_prev = io_pin_out[2];
        chk("osc_oe", io_pin_oe_n[2], 1'h0);
        repeat (40) begin cyc(1); n += int'(io_pin_out[2] && !osc_prev); osc_prev = io_pin_out[2]; end
        chk("osc_rate", n inside {[7:8]}, 1'h1);
        cfg.osc_enable = 1'b0;
        $display("test_map done");
    endtask : test_map
    task automatic test_auto;
        cfg.cable_replacement = 1'b1; cfg.is_master = 1'b1;
        cfg.reconnect_delay_setting = modem_line_pkg::RECONNECT_MIN_MS; cyc(2);
        chk("dial", connect_request, 1'h1);
        chk("master_hidden", connectable | discoverable, 1'h0);
        connect_failed = 1'b1; cyc(1); connect_failed = 1'b0;
        chk("wait", connect_request, 1'h0);
        n = 0;
        while (connect_request !== 1'h1 && n < 1100) begin cyc(1); n++; end
        chk("retry_time", n inside {[990:1010]}, 1'h1);
        link_up = 1'b1; cyc(2);
        chk("linked", connect_request, 1'h0);
        link_up = 1'b0; cyc(2);
        chk("relost", connect_request, 1'h0);
        $display("test_auto done");
    endtask : test_auto
    initial begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        cyc(3000); errors++; final_report();
    end
    initial begin
        {link_up, connect_failed, incoming_call, call_request, brk, rx_buffer_full} = '0;
        {answer_call_command, hang_up_command, store_peer_address_command} = '0;
        {ri_pin_in_n, dcd_pin_in_n, dsr_on} = '1;
        {io_pin_in, io_drive_value, io_drive_enable, incoming_addr, store_addr} = '0;
        {peer_in, line_map, cfg, errors, samples_checked} = '0;
        cfg.ri_is_output = 1; cfg.dcd_is_output = 1; cfg.pure_host_mode = 1;
        cfg.dsr_handling_setting = modem_line_pkg::DSR_DROP_ONLY;
        cfg.drop_timeout_ms = 16'h0003;
        reset_n = 0; cyc(3); reset_n = 1; cyc(2);
        test_call(); test_ring(); test_link(); test_break(); test_flow();
        test_map(); test_auto();
        final_report();
    end
endmodule : serial_modem_line_control_tb
